/* rtl/dfa_arith_unit.sv */
// The implementer's own choices: the plain strobed port and the placing of the registers.
`default_nettype none
`include "dfa_params.svh"
// What this block does
// - Only numeric bits are used; zone bits other than signs are kept.
// - Absolute option makes the memory operand positive; register signs stay true.
// - Add puts the sum in the upper 8-Y accumulator characters only.
// - Add and subtract copy the whole memory word into the auxiliary register.
// - Operand signs and command type pick true addition or true subtraction.
// - True subtraction takes field from 8-Y operand, keeping that operand's sign.
// - Borrow out flips the sign and runs a complement cycle from zero.
// - Carry out of the top result character sets the overflow toggle.
// - Add-to and subtract-from memory leave the result in upper auxiliary characters.
// - Long multiply gives a fractional product across accumulator and auxiliary.
// - Short multiply: low four accumulator digits times field, right-justified.
// - Long divide: 16-digit dividend, quotient to accumulator, remainder to auxiliary.
// - Long divide with too small divisor sets overflow and is abandoned.
// - Short divide is integer division; only a zero divisor sets overflow and abandons it.
// - Bad field digits or bad result digits set the non-numeric toggle.
// - Floating option sets the spec toggle on short multiply and short divide only; the command still runs.
// - Subtract with unlike signs adds magnitudes under the accumulator sign.
// - Add-to and subtract-from memory keep the accumulator; low auxiliary is memory.
// - Long multiply writes the product sign into both registers' low character.
module dfa_arith_unit (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [47:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [47:0]       reg_rdata_o,
  input  wire logic              start_i,
  input  wire dfa_pkg::dfa_cmd_t cmd_i,
  input  wire logic [6:0]        field_select_spec_i,
  input  wire logic              absolute_i,
  input  wire logic              float_i,
  input  wire logic [47:0]       mem_word_i,
  output logic [47:0]            acc_o,
  output logic [47:0]            aux_o,
  output logic                   overflow_o,
  output logic                   nonnumeric_o,
  output logic                   spec_err_o,
  output logic                   busy_o,
  output logic                   done_o
);
  import dfa_pkg::*;

  function automatic logic [31:0] dig_of(input logic [47:0] w);
    logic [31:0] d;
    d = '0;
    for (int i = 0; i < 8; i++) d[4*i +: 4] = w[`DFA_CHAR_W*i +: 4];
    return d;
  endfunction

  function automatic logic [47:0] put_dig(input logic [47:0] w, input logic [31:0] d,
                                          input logic [7:0] m);
    logic [47:0] r;
    r = w;
    for (int i = 0; i < 8; i++) if (m[i]) r[`DFA_CHAR_W*i +: 4] = d[4*i +: 4];
    return r;
  endfunction

  function automatic logic [47:0] set_sign(input logic [47:0] w, input logic [2:0] p,
                                           input logic s);
    logic [47:0] r;
    r = w;
    r[`DFA_CHAR_W*p + `DFA_SIGN_BIT] = s;
    return r;
  endfunction

  function automatic logic sign_of(input logic [47:0] w, input logic [2:0] p);
    return w[`DFA_CHAR_W*p + `DFA_SIGN_BIT];
  endfunction

  function automatic logic [7:0] fld_mask(input logic [3:0] z, input logic [2:0] y);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) m[i] = (i >= y) && (i < y + z);
    return m;
  endfunction

  function automatic logic [31:0] mask_dig(input logic [31:0] d, input logic [7:0] m);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) if (m[i]) r[4*i +: 4] = d[4*i +: 4];
    return r;
  endfunction

  function automatic logic bad_dig(input logic [31:0] d, input logic [7:0] m);
    logic b;
    b = 1'b0;
    for (int i = 0; i < 8; i++) b = b | (m[i] && (d[4*i +: 4] > 4'h9));
    return b;
  endfunction

  function automatic logic is_rmem(input dfa_cmd_t c);
    return (c == DFA_CMD_ADD_TO_R) || (c == DFA_CMD_SUB_FROM_R);
  endfunction

  dfa_state_t  state;
  dfa_cmd_t    cmd_q;
  logic [2:0]  y_q;
  logic [2:0]  cnt;
  logic [3:0]  rep;
  logic        sign_q;
  logic        tsub_q;
  logic [63:0] work;
  logic [63:0] oper;
  logic [31:0] dig_q;
  logic [47:0] acc_start;
  logic [63:0] add_a;
  logic [63:0] add_b;
  logic        add_sub;
  logic [63:0] add_y;
  logic        add_c;

  // Decode of the command being offered
  logic        take;
  logic [2:0]  s_y;
  logic [3:0]  s_z;
  logic [7:0]  fm;
  logic [7:0]  um;
  logic [31:0] adig;
  logic [31:0] mdig;
  logic [31:0] fr;
  logic [31:0] fl;
  logic        msign;
  logic        asign_y;
  logic        x_sign;
  logic        true_sub;
  logic        fld_bad;
  logic        div_bad;
  logic        spec_bad;
  assign take     = (state == DFA_ST_IDLE) && start_i;
  assign s_y      = field_select_spec_i[`DFA_SPEC_Y_MSB:`DFA_SPEC_Y_LSB];
  assign s_z      = field_select_spec_i[`DFA_SPEC_Z_MSB:`DFA_SPEC_Z_LSB];
  assign fm       = fld_mask(s_z, s_y);
  assign um       = fld_mask(`DFA_LONG_Z_MAX, s_y);
  assign adig     = dig_of(acc_o);
  assign mdig     = dig_of(mem_word_i);
  assign fr       = mask_dig(mdig, fm) >> (4 * s_y);
  assign fl       = fr << (4 * (8 - s_z));
  assign msign    = !absolute_i && sign_of(mem_word_i, s_y);
  assign asign_y  = sign_of(acc_o, s_y);
  // Both operands take their sign at the same low position
  assign x_sign   = is_rmem(cmd_i) ? msign : asign_y;
  assign true_sub = ((x_sign != (is_rmem(cmd_i) ? asign_y : msign))
                    ^ (cmd_i == DFA_CMD_SUB || cmd_i == DFA_CMD_SUB_FROM_R));
  assign fld_bad  = bad_dig(is_rmem(cmd_i) ? adig : mdig, fm);
  assign div_bad  = (cmd_i == DFA_CMD_DIV_LONG) ? (fr <= (adig >> (4 * (8 - s_z))))
                  : ((cmd_i == DFA_CMD_DIV_SHORT) && (fr == 32'h0));
  assign spec_bad = (float_i && (cmd_i == DFA_CMD_MUL_SHORT || cmd_i == DFA_CMD_DIV_SHORT))
                  || (cmd_i == DFA_CMD_MUL_SHORT && s_z > `DFA_SHORT_Z_MAX)
                  || (s_z > `DFA_LONG_Z_MAX);

  // One shared decimal adder; complement cycle subtracts from zero
  assign add_a   = (state == DFA_ST_CMPL) ? 64'h0 : work;
  assign add_b   = (state == DFA_ST_CMPL) ? work : oper;
  assign add_sub = (state == DFA_ST_CMPL) || (state == DFA_ST_DIV)
                || ((state == DFA_ST_ADD) && tsub_q);

  dfa_bcd_addsub #(.DIGITS(16)) u_adder (
    .a_i     (add_a),
    .b_i     (add_b),
    .sub_i   (add_sub),
    .y_o     (add_y),
    .carry_o (add_c)
  );

  logic fin_add;
  logic fin_mul;
  logic fin_div;
  assign fin_add = ((state == DFA_ST_ADD) && !(tsub_q && add_c)) || (state == DFA_ST_CMPL);
  assign fin_mul = (state == DFA_ST_MUL) && (rep == 4'h0) && (cnt == `DFA_LAST_DIGIT);
  assign fin_div = (state == DFA_ST_DIV) && add_c && (cnt == `DFA_LAST_DIGIT);

  // Result staging for the final write of each command
  logic [47:0] next_acc;
  logic [47:0] next_aux;
  logic        wr_acc;
  logic        wr_aux;
  logic        wr_bad;
  always_comb begin
    next_acc = acc_o;
    next_aux = aux_o;
    wr_acc   = 1'b0;
    wr_aux   = 1'b0;
    wr_bad   = 1'b0;
    if (fin_add) begin
      // Only the upper 8-Y numeric digits and the sign at Y change; other zones stay
      wr_bad = bad_dig(add_y[63:32], fld_mask(`DFA_LONG_Z_MAX, y_q));
      if (is_rmem(cmd_q)) begin
        next_aux = set_sign(put_dig(aux_o, add_y[63:32], fld_mask(`DFA_LONG_Z_MAX, y_q)),
                            y_q, sign_q ^ (state == DFA_ST_CMPL));
        wr_aux   = 1'b1;
      end else begin
        next_acc = set_sign(put_dig(acc_o, add_y[63:32], fld_mask(`DFA_LONG_Z_MAX, y_q)),
                            y_q, sign_q ^ (state == DFA_ST_CMPL));
        wr_acc   = 1'b1;
      end
    end else if (fin_mul) begin
      wr_acc = 1'b1;
      if (cmd_q == DFA_CMD_MUL_LONG) begin
        next_acc = set_sign(put_dig(acc_o, work[63:32], 8'hff), 3'h0, sign_q);
        next_aux = set_sign(put_dig(aux_o, work[31:0], 8'hff), 3'h0, sign_q);
        wr_aux   = 1'b1;
        wr_bad   = bad_dig(work[63:32], 8'hff) || bad_dig(work[31:0], 8'hff);
      end else begin
        next_acc = set_sign(put_dig(acc_o, work[31:0], 8'hff), 3'h0, sign_q);
        wr_bad   = bad_dig(work[31:0], 8'hff);
      end
    end else if (fin_div) begin
      // Quotient carries the product of signs, remainder the dividend's
      next_acc = set_sign(put_dig(acc_o, dig_q, 8'hff), 3'h0, sign_q);
      next_aux = set_sign(put_dig(aux_o, work[31:0], 8'hff), 3'h0, tsub_q);
      wr_acc   = 1'b1;
      wr_aux   = 1'b1;
      wr_bad   = bad_dig(work[31:0], 8'hff);
    end
  end

  // Sequencer: start decode, digit loops, completion
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state     <= DFA_ST_IDLE;
      cmd_q     <= DFA_CMD_ADD;
      y_q       <= 3'h0;
      cnt       <= 3'h0;
      rep       <= 4'h0;
      sign_q    <= 1'b0;
      tsub_q    <= 1'b0;
      work      <= 64'h0;
      oper      <= 64'h0;
      dig_q     <= 32'h0;
      acc_start <= `DFA_RST_WORD;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        DFA_ST_IDLE: begin
          if (start_i) begin
            cmd_q     <= cmd_i;
            y_q       <= s_y;
            cnt       <= 3'h0;
            busy_o    <= 1'b1;
            acc_start <= acc_o;
            if (cmd_i == DFA_CMD_MUL_LONG || cmd_i == DFA_CMD_MUL_SHORT) begin
              work   <= 64'h0;
              oper   <= (cmd_i == DFA_CMD_MUL_LONG) ? {32'h0, adig} : {48'h0, adig[15:0]};
              rep    <= (cmd_i == DFA_CMD_MUL_LONG) ? fl[31:28] : fr[31:28];
              dig_q  <= (cmd_i == DFA_CMD_MUL_LONG) ? (fl << 4) : (fr << 4);
              sign_q <= sign_of(acc_o, 3'h0) ^ msign;
              state  <= DFA_ST_MUL;
            end else if (cmd_i == DFA_CMD_DIV_LONG || cmd_i == DFA_CMD_DIV_SHORT) begin
              work   <= (cmd_i == DFA_CMD_DIV_LONG) ? {adig, dig_of(aux_o)} : {32'h0, adig};
              oper   <= {4'h0, ((cmd_i == DFA_CMD_DIV_LONG) ? fl : fr), 28'h0};
              dig_q  <= 32'h0;
              sign_q <= sign_of(acc_o, 3'h0) ^ msign;
              tsub_q <= sign_of(acc_o, 3'h0);
              // Too small a divisor abandons the divide untouched
              state  <= div_bad ? DFA_ST_DONE : DFA_ST_DIV;
            end else begin
              work   <= {mask_dig(is_rmem(cmd_i) ? mdig : adig, um), 32'h0};
              oper   <= {mask_dig(is_rmem(cmd_i) ? adig : mdig, fm), 32'h0};
              sign_q <= x_sign;
              tsub_q <= true_sub;
              state  <= DFA_ST_ADD;
            end
          end
        end
        DFA_ST_ADD: begin
          work  <= add_y;
          state <= (tsub_q && add_c) ? DFA_ST_CMPL : DFA_ST_DONE;
        end
        DFA_ST_CMPL: state <= DFA_ST_DONE;
        DFA_ST_MUL: begin
          // Repeated addition per multiplier digit, most significant first
          if (rep != 4'h0) begin
            work <= add_y;
            rep  <= rep - 4'h1;
          end else if (cnt == `DFA_LAST_DIGIT) begin
            state <= DFA_ST_DONE;
          end else begin
            work  <= work << 4;
            rep   <= dig_q[31:28];
            dig_q <= dig_q << 4;
            cnt   <= cnt + 3'h1;
          end
        end
        DFA_ST_DIV: begin
          // Restoring divide: no borrow means the divisor fitted once more
          if (!add_c) begin
            work         <= add_y;
            dig_q[3:0]   <= dig_q[3:0] + 4'h1;
          end else if (cnt == `DFA_LAST_DIGIT) begin
            state <= DFA_ST_DONE;
          end else begin
            dig_q <= dig_q << 4;
            oper  <= oper >> 4;
            cnt   <= cnt + 3'h1;
          end
        end
        DFA_ST_DONE: begin
          // Results were written on the way in, so done is safe now
          done_o <= 1'b1;
          busy_o <= 1'b0;
          state  <= DFA_ST_IDLE;
        end
        default: state <= DFA_ST_IDLE;
      endcase
    end
  end

  // Accumulator and auxiliary register; bus writes only while idle
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      acc_o <= `DFA_RST_WORD;
      aux_o <= `DFA_RST_WORD;
    end else begin
      if (reg_wr_i && !busy_o && reg_addr_i == `DFA_ADDR_ACC) acc_o <= reg_wdata_i;
      if (reg_wr_i && !busy_o && reg_addr_i == `DFA_ADDR_AUX) aux_o <= reg_wdata_i;
      if (take && (cmd_i <= DFA_CMD_SUB_FROM_R || cmd_i == DFA_CMD_MUL_SHORT)) begin
        aux_o <= mem_word_i;
      end
      if (wr_acc) acc_o <= next_acc;
      if (wr_aux) aux_o <= next_aux;
    end
  end

  // Error toggles: a set in the clearing cycle wins
  logic [47:0] clr;
  assign clr = (reg_wr_i && reg_addr_i == `DFA_ADDR_STAT) ? reg_wdata_i : 48'h0;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      overflow_o   <= 1'b0;
      nonnumeric_o <= 1'b0;
      spec_err_o   <= 1'b0;
    end else begin
      overflow_o   <= ((state == DFA_ST_ADD) && !tsub_q && add_c)
                    || (take && div_bad) || (overflow_o && !clr[`DFA_STAT_OVF]);
      nonnumeric_o <= (take && fld_bad) || wr_bad
                    || (nonnumeric_o && !clr[`DFA_STAT_NNUM]);
      spec_err_o   <= (take && spec_bad) || (spec_err_o && !clr[`DFA_STAT_SPEC]);
    end
  end

  // Read data stand for exactly one cycle after the strobe
  logic [47:0] stat_w;
  always_comb begin
    stat_w                 = 48'h0;
    stat_w[`DFA_STAT_OVF]  = overflow_o;
    stat_w[`DFA_STAT_NNUM] = nonnumeric_o;
    stat_w[`DFA_STAT_SPEC] = spec_err_o;
    stat_w[`DFA_STAT_BUSY] = busy_o;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 48'h0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 48'h0;
    end else if (reg_addr_i == `DFA_ADDR_ACC) begin
      reg_rdata_o <= acc_o;
    end else if (reg_addr_i == `DFA_ADDR_AUX) begin
      reg_rdata_o <= aux_o;
    end else if (reg_addr_i == `DFA_ADDR_STAT) begin
      reg_rdata_o <= stat_w;
    end else begin
      reg_rdata_o <= 48'h0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_borrow;
    (state == DFA_ST_ADD) && tsub_q && add_c;
  endsequence
  sequence s_cmpl_done;
    (state == DFA_ST_CMPL) ##1 (state == DFA_ST_DONE) ##1 done_o;
  endsequence
  sequence s_abort;
    (state == DFA_ST_DONE) && overflow_o ##1 done_o && $stable(acc_o);
  endsequence

  chk_cmpl_after_borrow: assert property (s_borrow |=> s_cmpl_done)
    else $error("complement cycle missing after borrow");
  chk_add_overflow: assert property ((state == DFA_ST_ADD) && !tsub_q && add_c
                                     |=> overflow_o)
    else $error("carry out did not set overflow");
  chk_aux_gets_word: assert property (take && cmd_i <= DFA_CMD_SUB
                                      |=> aux_o == $past(mem_word_i) && busy_o)
    else $error("auxiliary register lacks memory word");
  // Upper digits and the sign blanked: low characters and zones must not move
  chk_low_chars_kept: assert property (done_o && cmd_q <= DFA_CMD_SUB
      |-> set_sign(put_dig(acc_o, 32'h0, fld_mask(`DFA_LONG_Z_MAX, y_q)), y_q, 1'b0)
          == set_sign(put_dig(acc_start, 32'h0, fld_mask(`DFA_LONG_Z_MAX, y_q)), y_q, 1'b0))
    else $error("low accumulator characters changed");
  chk_acc_untouched: assert property (done_o && is_rmem(cmd_q) |-> acc_o == acc_start)
    else $error("accumulator changed by memory-result command");
  chk_div_abort: assert property (take && cmd_i == DFA_CMD_DIV_LONG && div_bad
                                  |=> s_abort)
    else $error("long divide not abandoned on overflow");
  chk_field_nonnum: assert property (take && fld_bad |=> nonnumeric_o)
    else $error("bad field digit missed");
  chk_mul_sign: assert property (done_o && cmd_q == DFA_CMD_MUL_LONG
      |-> acc_o[`DFA_SIGN_BIT] == aux_o[`DFA_SIGN_BIT] && acc_o[`DFA_SIGN_BIT] == sign_q)
    else $error("long product sign mismatch");
  // A start in the done cycle is legal, so look from the cycle after the take
  chk_done_bound: assert property (take |=> !done_o ##[0:119] done_o)
    else $error("command did not complete in time");
  chk_done_ends_busy: assert property (done_o |-> !busy_o && $past(busy_o))
    else $error("done without preceding busy");
endmodule
`default_nettype wire

/* common/dfa_params.svh */
`ifndef DFA_PARAMS_SVH
`define DFA_PARAMS_SVH
// Character layout: two zone bits over four numeric bits
`define DFA_CHAR_W      6
`define DFA_WORD_W      48
`define DFA_SIGN_BIT    4
// Field selection spec: Z (length) above Y (low position)
`define DFA_SPEC_Z_MSB  6
`define DFA_SPEC_Z_LSB  3
`define DFA_SPEC_Y_MSB  2
`define DFA_SPEC_Y_LSB  0
// Register port offsets
`define DFA_ADDR_ACC    4'h0
`define DFA_ADDR_AUX    4'h4
`define DFA_ADDR_STAT   4'h8
// Status bit positions
`define DFA_STAT_OVF    0
`define DFA_STAT_NNUM   1
`define DFA_STAT_SPEC   2
`define DFA_STAT_BUSY   3
// Reset values and loop limits
`define DFA_RST_WORD    48'h0
`define DFA_LAST_DIGIT  3'h7
`define DFA_SHORT_Z_MAX 4'h4
`define DFA_LONG_Z_MAX  4'h8
`endif

/* common/dfa_pkg.sv */
`default_nettype none
package dfa_pkg;
  typedef enum logic [2:0] {
    DFA_CMD_ADD        = 3'h0,
    DFA_CMD_SUB        = 3'h1,
    DFA_CMD_ADD_TO_R   = 3'h2,
    DFA_CMD_SUB_FROM_R = 3'h3,
    DFA_CMD_MUL_LONG   = 3'h4,
    DFA_CMD_MUL_SHORT  = 3'h5,
    DFA_CMD_DIV_LONG   = 3'h6,
    DFA_CMD_DIV_SHORT  = 3'h7
  } dfa_cmd_t;
  // Gray steps along idle, add, complement, done
  typedef enum logic [2:0] {
    DFA_ST_IDLE = 3'h0,
    DFA_ST_ADD  = 3'h1,
    DFA_ST_CMPL = 3'h3,
    DFA_ST_DONE = 3'h2,
    DFA_ST_MUL  = 3'h6,
    DFA_ST_DIV  = 3'h4
  } dfa_state_t;
endpackage
`default_nettype wire

/* rtl/dfa_bcd_addsub.sv */
`default_nettype none
module dfa_bcd_addsub #(
  parameter int DIGITS = 16
) (
  input  wire logic [4*DIGITS-1:0] a_i,
  input  wire logic [4*DIGITS-1:0] b_i,
  input  wire logic                sub_i,
  output logic      [4*DIGITS-1:0] y_o,
  output logic                     carry_o
);
  logic [DIGITS:0] c;

  if (DIGITS < 1) begin : g_bad
    $error("dfa_bcd_addsub needs at least one digit");
  end

  // Ripple through decimal digits; carry doubles as borrow
  assign c[0] = 1'b0;
  for (genvar g = 0; g < DIGITS; g++) begin : g_dig
    logic [4:0] sum;
    logic [4:0] dif;
    assign sum = {1'b0, a_i[4*g +: 4]} + {1'b0, b_i[4*g +: 4]} + {4'h0, c[g]};
    assign dif = {1'b0, a_i[4*g +: 4]} - {1'b0, b_i[4*g +: 4]} - {4'h0, c[g]};
    assign y_o[4*g +: 4] = sub_i ? (dif[4] ? dif[3:0] + 4'ha : dif[3:0])
                                 : ((sum > 5'h09) ? sum[3:0] + 4'h6 : sum[3:0]);
    assign c[g+1] = sub_i ? dif[4] : (sum > 5'h09);
  end
  assign carry_o = c[DIGITS];
endmodule
`default_nettype wire

/* testbench/dfa_seq_model.sv */
`default_nettype none
// Sequencer and memory side: presents one command with its operand word
module dfa_seq_model (
  input  wire logic               ref_clk_i,
  input  wire logic               done_i,
  output var  logic               start_o,
  output var  dfa_pkg::dfa_cmd_t  cmd_o,
  output var  logic [6:0]         spec_o,
  output var  logic               absolute_o,
  output var  logic               float_o,
  output var  logic [47:0]        mem_o
);
  import dfa_pkg::*;

  // Idle values at time zero
  initial begin
    start_o    = 1'h0;
    cmd_o      = DFA_CMD_ADD;
    spec_o     = 7'h0;
    absolute_o = 1'h0;
    float_o    = 1'h0;
    mem_o      = 48'h0;
  end

  // One command, then wait for completion under a bound
  task automatic issue(input dfa_cmd_t c, input logic [6:0] s, input logic [1:0] o,
                       input logic [47:0] m, output bit ok);
    ok = 1'b0;
    @(posedge ref_clk_i);
    start_o    <= 1'h1;
    cmd_o      <= c;
    spec_o     <= s;
    absolute_o <= o[0];
    float_o    <= o[1];
    mem_o      <= m;
    @(posedge ref_clk_i);
    start_o    <= 1'h0;
    mem_o      <= ~m; // Released bus must not look like the last word
    for (int n = 0; n < 120; n++) begin
      @(posedge ref_clk_i);
      // Look once the edge has settled, not in its own time step
      #1;
      if (done_i === 1'h1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
`include "dfa_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dfa_pkg::*;

  logic        clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [47:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [47:0] reg_rdata;
  logic        start;
  dfa_cmd_t    cmd;
  logic [6:0]  spec;
  logic        absolute;
  logic        flt;
  logic [47:0] mem;
  logic [47:0] acc;
  logic [47:0] aux;
  logic        ovf;
  logic        nnum;
  logic        spec_err;
  logic        busy;
  logic        done;
  int          err_total = 0;
  int          n_checks = 0;
  localparam logic [47:0] ZW = 48'h0;
  localparam logic [47:0] ZN = 48'h800000000000; // Zone bit of top char

  dfa_arith_unit u_dfa_arith_unit (
    .ref_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .start_i(start),
    .cmd_i(cmd), .field_select_spec_i(spec), .absolute_i(absolute), .float_i(flt),
    .mem_word_i(mem), .acc_o(acc), .aux_o(aux), .overflow_o(ovf), .nonnumeric_o(nnum),
    .spec_err_o(spec_err), .busy_o(busy), .done_o(done));

  dfa_seq_model u_dfa_seq_model (
    .ref_clk_i(clk), .done_i(done), .start_o(start), .cmd_o(cmd), .spec_o(spec),
    .absolute_o(absolute), .float_o(flt), .mem_o(mem));

  // 40 MHz clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Digits into characters, sign in zone bit of char p
  function automatic logic [47:0] mk(input logic [31:0] d, input logic neg, input int p);
    logic [47:0] w;
    w = '0;
    for (int i = 0; i < 8; i++) w[6*i +: 4] = d[4*i +: 4];
    w[6*p+4] = neg;
    return w;
  endfunction
  function automatic logic [47:0] p(input logic [31:0] d);
    return mk(d, 1'h0, 0);
  endfunction
  function automatic logic [47:0] n(input logic [31:0] d);
    return mk(d, 1'h1, 0);
  endfunction
  function automatic logic [47:0] q(input logic [31:0] d);
    return mk(d, 1'h0, 2);
  endfunction

  task automatic cmp_word(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flags(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected flags at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [47:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [47:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd   <= 1'h0;
    #1 d = reg_rdata;
  endtask

  // Preload A and R, run one command, check results, clear toggles
  task automatic run(input dfa_cmd_t c, input logic [6:0] s, input logic [1:0] o,
      input logic [47:0] ai, ri, m, ea, er, input logic [2:0] ef, input bit regs);
    bit ok;
    logic [47:0] st;
    wr(`DFA_ADDR_ACC, ai);
    wr(`DFA_ADDR_AUX, ri);
    u_dfa_seq_model.issue(c, s, o, m, ok);
    cmp_flags({2'h0, ok}, 3'h1);
    if (regs) begin
      cmp_word(acc, ea);
      cmp_word(aux, er);
    end
    cmp_flags({spec_err, nnum, ovf}, ef);
    cmp_flags({2'h0, busy}, 3'h0);
    rd(`DFA_ADDR_STAT, st);
    cmp_flags(st[3:1], {1'b0, ef[2:1]});
    cmp_flags({2'h0, st[0]}, {2'h0, ef[0]});
    wr(`DFA_ADDR_STAT, 48'h7);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, far beyond eighteen bounded commands
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    logic [47:0] d;
    rst_n     = 1'h0;
    reg_addr  = 4'h0;
    reg_wdata = 48'h0;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    cmp_word(acc, ZW);
    wr(`DFA_ADDR_ACC, 48'h123456789abc);
    rd(`DFA_ADDR_ACC, d);
    cmp_word(d, 48'h123456789abc);
    // Read data stand for one cycle only
    @(posedge clk);
    #1 cmp_word(reg_rdata, ZW);
    rd(4'hc, d);
    cmp_word(d, ZW);
    run(DFA_CMD_ADD, 7'h40, 2'h0, ZN | p(32'h5), ZW, p(32'h3), ZN | p(32'h8), p(32'h3),
        3'h0, 1'b1);
    run(DFA_CMD_ADD, 7'h12, 2'h0, q(32'h1199), ZW, q(32'h442200), q(32'h3399),
        q(32'h442200), 3'h0, 1'b1);
    run(DFA_CMD_SUB, 7'h40, 2'h0, p(32'h3), ZW, p(32'h5), n(32'h2), p(32'h5),
        3'h0, 1'b1);
    run(DFA_CMD_SUB, 7'h40, 2'h0, p(32'h5), ZW, n(32'h3), p(32'h8), n(32'h3),
        3'h0, 1'b1);
    run(DFA_CMD_ADD, 7'h40, 2'h0, p(32'h99999999), ZW, p(32'h1), ZW, p(32'h1),
        3'h1, 1'b1);
    run(DFA_CMD_ADD, 7'h40, 2'h1, p(32'h5), ZW, n(32'h3), p(32'h8), n(32'h3),
        3'h0, 1'b1);
    run(DFA_CMD_ADD_TO_R, 7'h12, 2'h0, q(32'h400), ZW, q(32'h30056), q(32'h400),
        q(32'h30456), 3'h0, 1'b1);
    run(DFA_CMD_SUB_FROM_R, 7'h40, 2'h0, p(32'h4), ZW, p(32'h9), p(32'h4), p(32'h5),
        3'h0, 1'b1);
    run(DFA_CMD_MUL_SHORT, 7'h08, 2'h0, p(32'h12), ZW, p(32'h3), p(32'h36), p(32'h3),
        3'h0, 1'b1);
    run(DFA_CMD_MUL_SHORT, 7'h08, 2'h2, p(32'h12), ZW, p(32'h3), p(32'h36), p(32'h3),
        3'h4, 1'b1);
    run(DFA_CMD_DIV_SHORT, 7'h08, 2'h3, p(32'h17), ZW, p(32'h5), p(32'h3), p(32'h2),
        3'h4, 1'b1);
    run(DFA_CMD_DIV_LONG, 7'h08, 2'h0, p(32'h50000000), ZW, p(32'h3), p(32'h50000000), ZW,
        3'h1, 1'b1);
    run(DFA_CMD_DIV_LONG, 7'h08, 2'h0, p(32'h10000000), ZW, p(32'h2), p(32'h50000000), ZW,
        3'h0, 1'b1);
    run(DFA_CMD_MUL_LONG, 7'h08, 2'h0, p(32'h50000000), ZW, n(32'h2), n(32'h10000000),
        n(32'h0), 3'h0, 1'b1);
    run(DFA_CMD_ADD, 7'h08, 2'h0, p(32'h1), ZW, p(32'ha), ZW, ZW, 3'h2, 1'b0);
    run(DFA_CMD_SUB_FROM_R, 7'h40, 2'h0, p(32'h9), ZW, p(32'h4), p(32'h9), n(32'h5),
        3'h0, 1'b1);
    run(DFA_CMD_MUL_SHORT, 7'h28, 2'h0, p(32'h12), ZW, p(32'h3), p(32'h36), p(32'h3),
        3'h4, 1'b1);
    run(DFA_CMD_DIV_SHORT, 7'h08, 2'h0, p(32'h17), ZW, p(32'h0), p(32'h17), ZW,
        3'h1, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
